// [core/bst_pkg.sv]
/*
 * Shared constants and types of the boundary-scan test port.
 * Assumes a single system clock samples the slow test clock.
 */
package bst_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam logic [IR_W-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hF;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 4'hB;
    localparam logic [IR_W-1:0] INSTR_HIGHZ = 4'h7;
    localparam logic [IR_W-1:0] INSTR_CLAMP = 4'h4;
    localparam logic [IR_W-1:0] INSTR_SAMPLE = 4'h8;
    localparam logic [IR_W-1:0] INSTR_CORE_RST = 4'hC;
    // Capture pattern: 01 in the two low bits, upper bits zero
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic BYP_CAPTURE = 1'b0;
    // Identification code field layout
    localparam int ID_REV_LSB = 28;
    localparam int ID_REV_W = 4;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_DEV_W = 16;
    localparam int ID_MFR_LSB = 1;
    localparam int ID_MFR_W = 11;
    localparam logic ID_PRESENT = 1'b1;
    // Consecutive high mode-select edges that reach reset
    localparam logic [2:0] TLR_ONES = 3'h5;
    localparam logic [2:0] ONES_MAX = 3'h7;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SELDR, TAP_CAPDR, TAP_SHDR, TAP_EX1DR, TAP_PAUDR,
        TAP_EX2DR, TAP_UPDDR, TAP_SELIR, TAP_CAPIR, TAP_SHIR, TAP_EX1IR,
        TAP_PAUIR, TAP_EX2IR, TAP_UPDIR
    } bst_tap_state_e;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_ID, SEL_RING
    } bst_chain_e;

    typedef struct packed {
        logic tms;
        logic tdi;
    } bst_tick_s;
endpackage

// [core/bst_tap.sv]
/*
 * Boundary-scan test port of the dual-port RAM: controller, instruction,
 * skip, identification and pin ring scan registers, pin drive muxing.
 * Assumes TCK runs far slower than CLK_SYS and the core sits behind the
 * CORE_* ports; the pads sit behind the PIN_* ports.
 */
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Sample test inputs on test clock rise
// - Unconnected mode-select reads high, stays in reset
// - Shift in at MSB, out at LSB
// - Serial out on fall, enabled when shifting
// - Five high mode-select edges reset controller
// - Pause and resume repeats next chain bit; the code repeats it only after Pause-DR, not after Pause-IR
// - Exactly one register between in and out
// - Four-bit instruction, identification after reset
// - Capture-IR loads 01 into low bits
// - Skip register cleared in Capture-DR
// - Ring register captures pins, shifts in Shift-DR
// - Identification code captured under identification instruction
// - New instruction effective only at Update-IR
// - External test drives outputs, captures inputs
// - Identification register shifted under identification
// - High-impedance: skip register, outputs floated
// - Sample/preload snapshots pins, updates held data
// - Bypass selects one-bit skip register
// - Clamp drives held values, skip register serial
// - Core-only reset resets core, not port
// - Outputs two cells, inputs one cell
// - Instruction codes decoded, others reserved
// - Code fields: revision, device, maker, one
module bst_tap
    import bst_pkg::*;
#(
    parameter int NUM_IN = 8,
    parameter int NUM_OUT = 8,
    parameter int BUF_DEPTH = 2,
    // Arbitrary identity values, not any real part
    parameter logic [ID_REV_W-1:0] ID_REV = 4'h0,
    parameter logic [ID_DEV_W-1:0] ID_DEV = 16'h1234,
    parameter logic [ID_MFR_W-1:0] ID_MFR = 11'h055
)(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE_N,
    input wire logic [NUM_IN-1:0] PIN_IN,
    output logic [NUM_IN-1:0] CORE_IN,
    input wire logic [NUM_OUT-1:0] CORE_OUT,
    input wire logic [NUM_OUT-1:0] CORE_OE_N,
    output logic [NUM_OUT-1:0] PIN_OUT,
    output logic [NUM_OUT-1:0] PIN_OE_N,
    output logic CORE_RESET,
    output logic BUF_READY
);
    localparam int NB = NUM_IN + 2 * NUM_OUT;
    localparam int AW = (BUF_DEPTH > 2) ? $clog2(BUF_DEPTH) : 1;
    localparam logic [ID_W-1:0] ID_CODE = {ID_REV, ID_DEV, ID_MFR, ID_PRESENT};

    if (NUM_IN < 1 || NUM_OUT < 1 || BUF_DEPTH < 2)
    begin : g_bad
        $error("bst_tap: pin counts must be positive and depth at least 2");
    end

    // Synchronisers; mode-select and data-in rest high like their pull-ups
    logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
    logic [NUM_IN-1:0] pin_s1, pin_s2;

    logic rise_ev, fall_ev;
    assign rise_ev = tck_s2 & ~tck_s3;
    assign fall_ev = ~tck_s2 & tck_s3;

    // Rise samples queue here; the engine stalls on fall events
    bst_tick_s fifo_mem [BUF_DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic buf_ready, next_buf_ready;
    logic push, pop;
    bst_tick_s head;

    assign push = rise_ev & buf_ready;
    assign pop = (count != '0) & ~fall_ev;
    assign head = fifo_mem[rd_ptr];

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push)
            next_wr_ptr = (wr_ptr == AW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        if (pop)
            next_rd_ptr = (rd_ptr == AW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
        next_buf_ready = (next_count != (AW+1)'(BUF_DEPTH));
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (push)
            fifo_mem[wr_ptr] <= '{tms: tms_s2, tdi: tdi_s2};
    end

    function automatic bst_tap_state_e tap_next(bst_tap_state_e s, logic m);
        bst_tap_state_e n;
        n = s;
        unique case (s)
            TAP_TLR: n = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: n = m ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: n = m ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: n = m ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR: n = m ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: n = m ? TAP_UPDDR : TAP_PAUDR;
            TAP_PAUDR: n = m ? TAP_EX2DR : TAP_PAUDR;
            TAP_EX2DR: n = m ? TAP_UPDDR : TAP_SHDR;
            TAP_UPDDR: n = m ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: n = m ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR: n = m ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR: n = m ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: n = m ? TAP_UPDIR : TAP_PAUIR;
            TAP_PAUIR: n = m ? TAP_EX2IR : TAP_PAUIR;
            TAP_EX2IR: n = m ? TAP_UPDIR : TAP_SHIR;
            TAP_UPDIR: n = m ? TAP_SELDR : TAP_RTI;
        endcase
        return n;
    endfunction

    // Test engine state
    bst_tap_state_e state, next_state;
    logic [IR_W-1:0] instr, next_instr, ir_shift, next_ir_shift;
    logic skip, next_skip, repeat_bit, next_repeat_bit;
    logic [ID_W-1:0] id_shift, next_id_shift;
    logic [NB-1:0] ring_shift, next_ring_shift, ring_hold, next_ring_hold;
    logic tdo, next_tdo, tdo_oe_n, next_tdo_oe_n;
    bst_chain_e sel;

    always_comb
    begin
        unique case (instr)
            INSTR_EXTEST, INSTR_SAMPLE: sel = SEL_RING;
            INSTR_IDCODE: sel = SEL_ID;
            default: sel = SEL_BYPASS;
        endcase
    end

    always_comb
    begin
        next_state = state;
        next_instr = instr;
        next_ir_shift = ir_shift;
        next_skip = skip;
        next_repeat_bit = repeat_bit;
        next_id_shift = id_shift;
        next_ring_shift = ring_shift;
        next_ring_hold = ring_hold;
        next_tdo = tdo;
        next_tdo_oe_n = tdo_oe_n;
        if (state == TAP_TLR)
            next_instr = INSTR_IDCODE;
        if (pop)
        begin
            next_state = tap_next(state, head.tms);
            unique case (state)
                TAP_CAPIR: next_ir_shift = IR_CAPTURE;
                TAP_SHIR: next_ir_shift = {head.tdi, ir_shift[IR_W-1:1]};
                TAP_CAPDR:
                    unique case (sel)
                        SEL_BYPASS: next_skip = BYP_CAPTURE;
                        SEL_ID: next_id_shift = ID_CODE;
                        SEL_RING: next_ring_shift = {CORE_OE_N, CORE_OUT, pin_s2};
                    endcase
                TAP_SHDR:
                    if (repeat_bit)
                        next_repeat_bit = 1'b0;
                    else
                        unique case (sel)
                            SEL_BYPASS: next_skip = head.tdi;
                            SEL_ID: next_id_shift = {head.tdi, id_shift[ID_W-1:1]};
                            SEL_RING: next_ring_shift = {head.tdi, ring_shift[NB-1:1]};
                        endcase
                TAP_EX2DR: next_repeat_bit = ~head.tms;
                default: ;
            endcase
        end
        if (fall_ev)
        begin
            next_tdo_oe_n = ~(state == TAP_SHIR || state == TAP_SHDR);
            if (state == TAP_SHIR)
                next_tdo = ir_shift[0];
            else if (state == TAP_SHDR)
                unique case (sel)
                    SEL_BYPASS: next_tdo = skip;
                    SEL_ID: next_tdo = id_shift[0];
                    SEL_RING: next_tdo = ring_shift[0];
                endcase
            if (state == TAP_UPDIR)
                next_instr = ir_shift;
            if (state == TAP_UPDDR && sel == SEL_RING)
                next_ring_hold = ring_shift;
        end
    end

    // Pin drive; ring layout: inputs low, output data, then output enables
    logic [NUM_OUT-1:0] next_pin_out, next_pin_oe_n;
    logic drive_held, next_core_reset;

    always_comb
    begin
        drive_held = (instr == INSTR_EXTEST) || (instr == INSTR_CLAMP);
        next_pin_out = drive_held ? ring_hold[NUM_IN +: NUM_OUT] : CORE_OUT;
        next_pin_oe_n = drive_held ? ring_hold[NUM_IN + NUM_OUT +: NUM_OUT] : CORE_OE_N;
        if (instr == INSTR_HIGHZ)
            next_pin_oe_n = '1;
        // Test port reset alone never touches the core
        next_core_reset = (instr == INSTR_CORE_RST);
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
            pin_s1 <= '0;
            pin_s2 <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            buf_ready <= 1'b1;
            state <= TAP_TLR;
            instr <= INSTR_IDCODE;
            ir_shift <= IR_CAPTURE;
            skip <= BYP_CAPTURE;
            repeat_bit <= 1'b0;
            id_shift <= '0;
            ring_shift <= '0;
            ring_hold <= '0;
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
            PIN_OUT <= '0;
            PIN_OE_N <= '1;
            CORE_RESET <= 1'b0;
        end
        else
        begin
            tck_s1 <= TCK;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= TMS;
            tms_s2 <= tms_s1;
            tdi_s1 <= TDI;
            tdi_s2 <= tdi_s1;
            pin_s1 <= PIN_IN;
            pin_s2 <= pin_s1;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            buf_ready <= next_buf_ready;
            state <= next_state;
            instr <= next_instr;
            ir_shift <= next_ir_shift;
            skip <= next_skip;
            repeat_bit <= next_repeat_bit;
            id_shift <= next_id_shift;
            ring_shift <= next_ring_shift;
            ring_hold <= next_ring_hold;
            tdo <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
            PIN_OUT <= next_pin_out;
            PIN_OE_N <= next_pin_oe_n;
            CORE_RESET <= next_core_reset;
        end
    end

    assign CORE_IN = pin_s2;
    assign TDO = tdo;
    assign TDO_OE_N = tdo_oe_n;
    assign BUF_READY = buf_ready;

    // Helper: consecutive processed edges with mode-select high
    logic [2:0] ones;
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            ones <= '0;
        else if (pop)
            ones <= !head.tms ? '0 : (ones == ONES_MAX) ? ones : ones + 1'b1;
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    sequence s_edge_in(bst_tap_state_e st);
        pop && state == st;
    endsequence

    AST_FIVE_ONES_RESET: assert property (ones >= TLR_ONES |-> state == TAP_TLR)
        else $error("five high mode-select edges did not reset controller");
    AST_RESET_LOADS_ID: assert property (state == TAP_TLR |=> instr == INSTR_IDCODE)
        else $error("reset state did not load identification instruction");
    AST_TDO_ON_FALL: assert property (!$stable(TDO) |-> $past(fall_ev))
        else $error("serial output changed away from a falling edge");
    AST_TDO_OE_SHIFT: assert property (fall_ev ##1 !TDO_OE_N |-> $past(state == TAP_SHDR || state == TAP_SHIR))
        else $error("serial output enabled outside shift states");
    AST_CAPIR_01: assert property (s_edge_in(TAP_CAPIR) |=> ir_shift[1:0] == 2'b01)
        else $error("capture-IR pattern wrong");
    AST_SKIP_CLEAR: assert property (s_edge_in(TAP_CAPDR) ##0 sel == SEL_BYPASS |=> !skip)
        else $error("skip register not cleared on capture");
    AST_ID_CAPTURE: assert property (s_edge_in(TAP_CAPDR) ##0 sel == SEL_ID |=> id_shift == ID_CODE)
        else $error("identification code not captured");
    AST_REPEAT_BIT: assert property (s_edge_in(TAP_SHDR) ##0 repeat_bit |=> $stable(id_shift) && $stable(ring_shift))
        else $error("first shift after resume did not hold the chain");
    AST_UPDATE_IR: assert property (!$stable(instr) |-> $past(state == TAP_TLR || (state == TAP_UPDIR && fall_ev)))
        else $error("instruction changed outside Update-IR or reset");
    AST_HIGHZ_FLOAT: assert property (instr == INSTR_HIGHZ |=> PIN_OE_N == '1)
        else $error("high-impedance instruction left a driver on");
    AST_CORE_RESET: assert property (instr == INSTR_CORE_RST |=> CORE_RESET)
        else $error("core-only reset not asserted");
endmodule
`default_nettype wire

// [bench/bst_tester.sv]
/*
 * Scan tester model: drives test clock, mode select and serial in.
 * Assumes the bench calls step once per 125 ns test clock period.
 */
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    // Clock stands low between steps
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Line is read just before the rise; a released line has no pull-up,
    // so the model shows it inverted to expose any late enable
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #62.5;
        o = tdo_oe_n ? ~tdo : tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask
endmodule
`default_nettype wire

// [bench/bst_tap_tb.sv]
/*
 * Self-checking bench of the test port: scans through the tester model.
 * Assumes default widths of eight inputs and eight outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_tb
    import bst_pkg::*;
;
    // Code of the instance's arbitrary identity defaults
    localparam logic [31:0] ID_EXP = {4'h0, 16'h1234, 11'h055, ID_PRESENT};
    localparam logic [10:0] PAUSE_WALK = 11'h282;
    logic clk_sys, rst, tck, tms, tdi, tdo, tdo_oe_n, core_reset, buf_ready;
    logic [7:0] pin_in, core_in, core_out, core_oe_n, pin_out, pin_oe_n, e;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] d;
    logic o0, o1, o2;
    logic [3:0] codes [5] = '{INSTR_HIGHZ, INSTR_CLAMP, INSTR_BYPASS, 4'h3, INSTR_CORE_RST};

    bst_tap u_bst_tap (
        .CLK_SYS(clk_sys), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
        .TDO(tdo), .TDO_OE_N(tdo_oe_n), .PIN_IN(pin_in), .CORE_IN(core_in),
        .CORE_OUT(core_out), .CORE_OE_N(core_oe_n), .PIN_OUT(pin_out),
        .PIN_OE_N(pin_oe_n), .CORE_RESET(core_reset), .BUF_READY(buf_ready)
    );
    bst_tester u_bst_tester (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    // From idle through capture, n shifts, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = '0;
        u_bst_tester.step(1'b1, 1'b0, o);
        if (ir)
            u_bst_tester.step(1'b1, 1'b0, o);
        u_bst_tester.step(1'b0, 1'b0, o);
        u_bst_tester.step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            u_bst_tester.step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        u_bst_tester.step(1'b1, 1'b0, o);
        u_bst_tester.step(1'b0, 1'b0, o);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        final_report;
    end

    initial
    begin
        rst = 1'b1;
        pin_in = 8'h3C;
        core_out = 8'h5A;
        core_oe_n = 8'hA0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(tdo_oe_n, 1'b1, "serial out idle");
        chk(core_in, 8'h3C, "input pass");
        u_bst_tester.step(1'b0, 1'b0, o0);
        scan(1'b0, 32, 32'h0, d);
        chk(d, ID_EXP, "id after reset");
        done("id");

        scan(1'b1, 4, {28'h0, INSTR_SAMPLE}, d);
        chk(d[1:0], 2'b01, "ir capture");
        scan(1'b0, 24, {8'hC3, 8'h96, 8'h00}, d);
        chk(d, 32'h00A05A3C, "sample snapshot");
        chk(pin_out, 8'h5A, "sample keeps core drive");
        scan(1'b1, 4, {28'h0, INSTR_EXTEST}, d);
        chk({pin_oe_n, pin_out}, 16'hC396, "preload drive");
        @(posedge clk_sys);
        pin_in <= 8'hE1;
        scan(1'b0, 24, {8'h3C, 8'h0F, 8'h00}, d);
        chk(d[7:0], 8'hE1, "input capture");
        chk({pin_oe_n, pin_out}, 16'h3C0F, "extest update");
        done("ring");

        for (int k = 0; k < 5; k++)
        begin
            scan(1'b1, 4, {28'h0, codes[k]}, d);
            chk(d[1:0], 2'b01, "ir capture");
            scan(1'b0, 8, 32'hA5, d);
            chk(d, 32'h4A, "one-bit path");
            chk(core_reset, codes[k] == INSTR_CORE_RST, "core reset");
            e = codes[k] == INSTR_CLAMP ? 8'h3C : 8'hA0;
            e = codes[k] == INSTR_HIGHZ ? 8'hFF : e;
            chk(pin_oe_n, e, "drive enables");
            if (codes[k] != INSTR_HIGHZ)
                chk(pin_out, codes[k] == INSTR_CLAMP ? 8'h0F : 8'h5A, "drive data");
        end
        done("one-bit");

        for (int k = 0; k < 5; k++)
            u_bst_tester.step(1'b1, 1'b0, o0);
        chk(core_reset, 1'b0, "tap reset");
        chk({pin_oe_n, pin_out}, 16'hA05A, "pins undisturbed");
        done("tap reset");

        // Deliberate pause walk, the one place the tester enters Pause-DR
        for (int k = 0; k < 11; k++)
            u_bst_tester.step(PAUSE_WALK[k], 1'b0, o0);
        u_bst_tester.step(1'b0, 1'b0, o0);
        u_bst_tester.step(1'b0, 1'b0, o1);
        u_bst_tester.step(1'b1, 1'b0, o2);
        u_bst_tester.step(1'b1, 1'b0, o2);
        u_bst_tester.step(1'b0, 1'b0, o2);
        chk({o0, o1}, {ID_EXP[4], ID_EXP[4]}, "repeated bit");
        chk(buf_ready, 1'b1, "no dropped sample");
        done("pause");
        final_report;
    end
endmodule
`default_nettype wire
